// file: verilog/fws_host.sv
/*
  fws_host: host side of the flash write-status protocol. software orders single
  reads and writes or a completion poll (toggle or data polling); the controller
  runs the flash strobes and reports the outcome.
  assumes: dq_i and ready_busy_n synchronous to clk_sys; the pad ring resolves the
  data bus from dq_oe_n; registers reached over AXI4-Lite.
*/
// Local design decisions: the AXI4-Lite slave port and the placing of the registers.
`timescale 1ns/100ps
module fws_host #(
  parameter int RD_NS = 70,
  parameter int WP_NS = 100,
  parameter int GAP_NS = 100
) (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic [fws_pkg::AXI_AW-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [fws_pkg::AXI_AW-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output fws_pkg::fws_pins_t pins,
  input wire logic [15:0] dq_i,
  input wire logic ready_busy_n
);

  function automatic logic [7:0] ns2cyc(input int ns);
    int c;
    c = (ns + fws_pkg::CLK_NS - 1) / fws_pkg::CLK_NS;
    if (c < 1)
    begin
      c = 1;
    end
    return c[7:0];
  endfunction

  function automatic logic mapped(input logic [fws_pkg::AXI_AW-1:0] a);
    return a == fws_pkg::OFS_CTRL || a == fws_pkg::OFS_ADDR || a == fws_pkg::OFS_WDATA
        || a == fws_pkg::OFS_STATUS || a == fws_pkg::OFS_RDATA || a == fws_pkg::OFS_RSTW;
  endfunction

  localparam logic [7:0] RD_CYC = ns2cyc(RD_NS);
  localparam logic [7:0] WP_CYC = ns2cyc(WP_NS);
  localparam logic [7:0] GAP_CYC = ns2cyc(GAP_NS);

  // strobe times must fit the 8-bit strobe counter
  if (RD_NS / fws_pkg::CLK_NS > 200 || WP_NS / fws_pkg::CLK_NS > 200
      || GAP_NS / fws_pkg::CLK_NS > 200)
  begin : g_range_chk
    $error("fws_host: strobe time beyond counter range");
  end

  typedef enum logic [2:0] {S_IDLE, S_RD, S_RHI, S_WR, S_WHI, S_EVAL} fws_state_t;

  // register bank and bus slave
  logic aw_have_r, aw_have_nxt, w_have_r, w_have_nxt, bvalid_r, bvalid_nxt;
  logic [fws_pkg::AXI_AW-1:0] aw_addr_r, aw_addr_nxt;
  logic [31:0] wd_r, wd_nxt, rdata_r, rdata_nxt;
  logic rvalid_r, rvalid_nxt;
  logic [1:0] bresp_r, bresp_nxt, rresp_r, rresp_nxt;
  logic [21:0] addr_r, addr_nxt;
  logic [15:0] wdat_r, wdat_nxt, rstw_r, rstw_nxt;
  logic auto_r, auto_nxt;
  logic go, stop;
  fws_pkg::fws_op_t op_req;

  // engine
  fws_state_t st_r, st_nxt;
  fws_pkg::fws_op_t op_r, op_nxt;
  fws_pkg::fws_res_t res_r, res_nxt;
  logic [1:0] step_r, step_nxt;
  logic [7:0] cnt_r, cnt_nxt;
  logic [15:0] rd_r, rd_nxt, prev_r, prev_nxt;
  logic stop_r, stop_nxt;
  fws_pkg::fws_pins_t pins_r, pins_nxt;

  logic wr_fire;
  logic [31:0] status_word;

  assign s_axi_awready = !aw_have_r && !bvalid_r;
  assign s_axi_wready = !w_have_r && !bvalid_r;
  assign s_axi_arready = !rvalid_r;
  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rdata = rdata_r;
  assign s_axi_rresp = rresp_r;
  assign pins = pins_r;
  assign status_word = {27'h000_0000, ready_busy_n, res_r, st_r != S_IDLE};

  always_comb
  begin
    aw_have_nxt = aw_have_r || (s_axi_awvalid && s_axi_awready);
    w_have_nxt = w_have_r || (s_axi_wvalid && s_axi_wready);
    aw_addr_nxt = (s_axi_awvalid && s_axi_awready) ? s_axi_awaddr : aw_addr_r;
    wd_nxt = (s_axi_wvalid && s_axi_wready) ? s_axi_wdata : wd_r;
    bvalid_nxt = bvalid_r && !s_axi_bready;
    bresp_nxt = bresp_r;
    addr_nxt = addr_r;
    wdat_nxt = wdat_r;
    rstw_nxt = rstw_r;
    auto_nxt = auto_r;
    go = 1'b0;
    stop = 1'b0;
    op_req = fws_pkg::OP_READ;
    wr_fire = aw_have_r && w_have_r && !bvalid_r;
    if (wr_fire)
    begin
      aw_have_nxt = 1'b0;
      w_have_nxt = 1'b0;
      bvalid_nxt = 1'b1;
      bresp_nxt = mapped(aw_addr_r) ? fws_pkg::AXI_OKAY : fws_pkg::AXI_SLVERR;
      unique case (aw_addr_r)
        fws_pkg::OFS_CTRL:
        begin
          auto_nxt = wd_r[fws_pkg::CTRL_AUTO];
          go = wd_r[fws_pkg::CTRL_GO];
          stop = wd_r[fws_pkg::CTRL_STOP];
          op_req = fws_pkg::fws_op_t'(wd_r[fws_pkg::CTRL_OP_LSB +: 3]);
        end
        fws_pkg::OFS_ADDR: addr_nxt = wd_r[21:0];
        fws_pkg::OFS_WDATA: wdat_nxt = wd_r[15:0];
        fws_pkg::OFS_RSTW: rstw_nxt = wd_r[15:0];
        default: ;
      endcase
    end
    rvalid_nxt = rvalid_r && !s_axi_rready;
    rdata_nxt = rdata_r;
    rresp_nxt = rresp_r;
    if (s_axi_arvalid && s_axi_arready)
    begin
      rvalid_nxt = 1'b1;
      rresp_nxt = mapped(s_axi_araddr) ? fws_pkg::AXI_OKAY : fws_pkg::AXI_SLVERR;
      unique case (s_axi_araddr)
        fws_pkg::OFS_CTRL: rdata_nxt = {27'h000_0000, auto_r, 1'b0, 3'(op_r)};
        fws_pkg::OFS_ADDR: rdata_nxt = {10'h000, addr_r};
        fws_pkg::OFS_WDATA: rdata_nxt = {16'h0000, wdat_r};
        fws_pkg::OFS_STATUS: rdata_nxt = status_word;
        fws_pkg::OFS_RDATA: rdata_nxt = {16'h0000, rd_r};
        fws_pkg::OFS_RSTW: rdata_nxt = {16'h0000, rstw_r};
        default: rdata_nxt = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      aw_have_r <= 1'b0;
      w_have_r <= 1'b0;
      aw_addr_r <= '0;
      wd_r <= 32'h0000_0000;
      bvalid_r <= 1'b0;
      bresp_r <= fws_pkg::AXI_OKAY;
      rvalid_r <= 1'b0;
      rdata_r <= 32'h0000_0000;
      rresp_r <= fws_pkg::AXI_OKAY;
      addr_r <= '0;
      wdat_r <= 16'h0000;
      rstw_r <= 16'h0000;
      auto_r <= 1'b0;
    end
    else
    begin
      aw_have_r <= aw_have_nxt;
      w_have_r <= w_have_nxt;
      aw_addr_r <= aw_addr_nxt;
      wd_r <= wd_nxt;
      bvalid_r <= bvalid_nxt;
      bresp_r <= bresp_nxt;
      rvalid_r <= rvalid_nxt;
      rdata_r <= rdata_nxt;
      rresp_r <= rresp_nxt;
      addr_r <= addr_nxt;
      wdat_r <= wdat_nxt;
      rstw_r <= rstw_nxt;
      auto_r <= auto_nxt;
    end
  end

  // flash strobe sequencer and completion check
  always_comb
  begin
    st_nxt = st_r;
    op_nxt = op_r;
    res_nxt = res_r;
    step_nxt = step_r;
    cnt_nxt = (cnt_r != 8'h00) ? cnt_r - 8'h01 : cnt_r;
    rd_nxt = rd_r;
    prev_nxt = prev_r;
    // a stop request is kept until the engine returns to idle; one made while idle is dropped unless the same write sets go
    stop_nxt = stop_r || stop;
    pins_nxt = pins_r;
    // every status read goes to the one programmed address
    pins_nxt.addr = addr_r;
    unique case (st_r)
      S_IDLE:
      begin
        if (go)
        begin
          op_nxt = op_req;
          res_nxt = fws_pkg::RES_NONE;
          step_nxt = 2'd0;
          if (op_req == fws_pkg::OP_WRITE)
          begin
            res_nxt = fws_pkg::RES_OK;
            st_nxt = S_WR;
            pins_nxt = '{1'b0, 1'b1, 1'b0, 1'b0, addr_r, wdat_r};
            cnt_nxt = WP_CYC;
          end
          else
          begin
            st_nxt = S_RD;
            pins_nxt = '{1'b0, 1'b0, 1'b1, 1'b1, addr_r, 16'h0000};
            cnt_nxt = RD_CYC;
          end
        end
      end
      S_RD:
      begin
        if (cnt_r == 8'h01)
        begin
          rd_nxt = dq_i;
          // drop both enables so the next read is a fresh cycle
          pins_nxt.ce_n = 1'b1;
          pins_nxt.oe_n = 1'b1;
          cnt_nxt = GAP_CYC;
          st_nxt = S_RHI;
        end
      end
      S_RHI:
      begin
        if (cnt_r == 8'h01)
        begin
          st_nxt = S_EVAL;
        end
      end
      S_WR:
      begin
        if (cnt_r == 8'h01)
        begin
          pins_nxt.we_n = 1'b1;
          pins_nxt.ce_n = 1'b1;
          cnt_nxt = GAP_CYC;
          st_nxt = S_WHI;
        end
      end
      S_WHI:
      begin
        if (cnt_r == 8'h01)
        begin
          pins_nxt.dq_oe_n = 1'b1;
          st_nxt = S_IDLE;
        end
      end
      S_EVAL:
      begin
        st_nxt = S_RD;
        prev_nxt = rd_r;
        step_nxt = step_r + 2'd1;
        if (stop_r || stop)
        begin
          res_nxt = fws_pkg::RES_STOPPED;
          st_nxt = S_IDLE;
        end
        else if (op_r == fws_pkg::OP_READ)
        begin
          res_nxt = fws_pkg::RES_OK;
          st_nxt = S_IDLE;
        end
        else if (op_r == fws_pkg::OP_TOGGLE && step_r[0])
        begin
          // second read of a pair: equal toggle bits mean finished
          if (rd_r[fws_pkg::DQ_TOG1] == prev_r[fws_pkg::DQ_TOG1])
          begin
            res_nxt = fws_pkg::RES_OK;
            st_nxt = S_IDLE;
          end
          else if (step_r == 2'd3)
          begin
            res_nxt = fws_pkg::RES_FAIL;
          end
          else if (rd_r[fws_pkg::DQ_ABORT])
          begin
            res_nxt = fws_pkg::RES_ABORT;
            st_nxt = S_IDLE;
          end
          else if (!rd_r[fws_pkg::DQ_LIMIT])
          begin
            step_nxt = 2'd0; // still busy: start over with a new pair
          end
        end
        else if (op_r == fws_pkg::OP_DATA)
        begin
          // data polling at the last loaded address
          if (step_r == 2'd1)
          begin
            res_nxt = fws_pkg::RES_OK; // array data read back after completion
            st_nxt = S_IDLE;
          end
          else if (rd_r[fws_pkg::DQ_POLL] == wdat_r[fws_pkg::DQ_POLL])
          begin
            step_nxt = 2'd1;
          end
          else if (step_r == 2'd2)
          begin
            res_nxt = fws_pkg::RES_FAIL;
          end
          else if (rd_r[fws_pkg::DQ_ABORT])
          begin
            res_nxt = fws_pkg::RES_ABORT;
            st_nxt = S_IDLE;
          end
          else
          begin
            step_nxt = rd_r[fws_pkg::DQ_LIMIT] ? 2'd2 : 2'd0;
          end
        end
        if (res_nxt == fws_pkg::RES_FAIL)
        begin
          st_nxt = S_IDLE;
          if (auto_r)
          begin
            // failure: put the device back to reading with the reset word
            st_nxt = S_WR;
            pins_nxt = '{1'b0, 1'b1, 1'b0, 1'b0, addr_r, rstw_r};
            cnt_nxt = WP_CYC;
          end
        end
        else if (st_nxt == S_RD)
        begin
          pins_nxt.ce_n = 1'b0;
          pins_nxt.oe_n = 1'b0;
          cnt_nxt = RD_CYC;
        end
      end
      default: st_nxt = S_IDLE;
    endcase
    if (st_nxt == S_IDLE)
    begin
      stop_nxt = 1'b0;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      st_r <= S_IDLE;
      op_r <= fws_pkg::OP_READ;
      res_r <= fws_pkg::RES_NONE;
      step_r <= 2'd0;
      cnt_r <= 8'h00;
      rd_r <= 16'h0000;
      prev_r <= 16'h0000;
      stop_r <= 1'b0;
      pins_r <= '{1'b1, 1'b1, 1'b1, 1'b1, 22'h00_0000, 16'h0000};
    end
    else
    begin
      st_r <= st_nxt;
      op_r <= op_nxt;
      res_r <= res_nxt;
      step_r <= step_nxt;
      cnt_r <= cnt_nxt;
      rd_r <= rd_nxt;
      prev_r <= prev_nxt;
      stop_r <= stop_nxt;
      pins_r <= pins_nxt;
    end
  end

endmodule // fws_host

// file: verilog/fws_pkg.sv
/*
  fws_pkg: constants, register map, field positions and carrier types for the
  flash write-status host controller.
  assumes: a parallel NOR flash with active-low strobes on the far side and
  software reaching the controller registers over AXI4-Lite with 32-bit data.
*/
package fws_pkg;

  localparam int CLK_NS = 100;
  localparam int AXI_AW = 8;

  // register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_ADDR = 8'h04;
  localparam logic [7:0] OFS_WDATA = 8'h08;
  localparam logic [7:0] OFS_STATUS = 8'h0C;
  localparam logic [7:0] OFS_RDATA = 8'h10;
  localparam logic [7:0] OFS_RSTW = 8'h14;

  // control register fields
  localparam int CTRL_OP_LSB = 0;
  localparam int CTRL_GO = 3;
  localparam int CTRL_AUTO = 4;
  localparam int CTRL_STOP = 5;

  // status register fields
  localparam int ST_BUSY = 0;
  localparam int ST_RES_LSB = 1;
  localparam int ST_RB = 4;

  // status bit positions on the flash data bus
  localparam int DQ_POLL = 7;
  localparam int DQ_TOG1 = 6;
  localparam int DQ_LIMIT = 5;
  localparam int DQ_ABORT = 1;

  localparam logic [1:0] AXI_OKAY = 2'h0;
  localparam logic [1:0] AXI_SLVERR = 2'h2;

  typedef enum logic [2:0] {OP_READ, OP_WRITE, OP_TOGGLE, OP_DATA} fws_op_t;
  typedef enum logic [2:0] {RES_NONE, RES_OK, RES_FAIL, RES_ABORT, RES_STOPPED} fws_res_t;

  typedef struct packed {
    logic ce_n;
    logic oe_n;
    logic we_n;
    logic dq_oe_n;
    logic [21:0] addr;
    logic [15:0] dq_o;
  } fws_pins_t;

endpackage

// file: sim/fws_host_monitor.sv
/*
  fws_host_monitor: port checks on the flash strobes and the register bus.
  assumes: bound into fws_host; one clock, rst_b active low.
*/
`timescale 1ns/100ps
module fws_host_monitor (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire fws_pkg::fws_pins_t pins
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_b);
  sequence s_idle;
    pins.oe_n && pins.ce_n;
  endsequence
  sequence s_held;
    pins.we_n && !pins.dq_oe_n && $stable(pins.dq_o);
  endsequence
  sequence s_pair;
    !pins.oe_n ##1 pins.oe_n [*2] ##1 !pins.oe_n;
  endsequence
  a_read_pulse: assert property ($fell(pins.oe_n) |-> !pins.ce_n ##1 s_idle [*2])
    else $error("read strobe without a two cycle gap");
  a_poll_addr: assert property (s_pair |-> pins.addr == $past(pins.addr, 3))
    else $error("status reads of one poll at different addresses");
  a_no_contend: assert property (!pins.oe_n |-> pins.dq_oe_n && pins.we_n)
    else $error("host drives the bus during a read");
  a_write_hold: assert property ($fell(pins.we_n) |-> !pins.ce_n && !pins.dq_oe_n ##1 s_held)
    else $error("write data not held past the strobe");
  a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
    && s_axi_wready |-> ##2 s_axi_bvalid)
    else $error("write response late");
  a_one_bresp: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write response repeated");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read response late");
  a_ar_blocked: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read address taken while a response waits");
endmodule // fws_host_monitor

// file: sim/fws_flash_model.sv
/*
  fws_flash_model: behavioural flash that reports status while programming.
  assumes: pins registered on clk_sys; the bench picks the fault of each program.
*/
`timescale 1ns/100ps
module fws_flash_model #(
  parameter logic [15:0] RST_CMD = 16'h00F0,
  parameter logic [15:0] ERS_CMD = 16'h0030
) (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire fws_pkg::fws_pins_t pins,
  input wire logic [1:0] fault,
  input wire logic [7:0] busy_len,
  output logic [15:0] dq_i,
  output logic ready_busy_n
);
  logic [15:0] mem_r [16];
  logic [15:0] wd_r, last_r, rd;
  logic [7:0] cnt_r;
  logic [1:0] flt_r;
  logic tog_r, rd_d_r, wr_d_r, busy, rd_on, ers_r;
  assign busy = (cnt_r != 8'h00) || (flt_r != 2'h0);
  assign ready_busy_n = !busy;
  assign rd_on = !pins.ce_n && !pins.oe_n;
  // status at any address; the erase flag and second toggle move only while erasing
  assign rd = busy ? {8'h00, ers_r ? 1'b0 : ~wd_r[7], tog_r, flt_r[0], 1'h0, ers_r,
    ers_r & tog_r, flt_r[1], 1'h0}
    : mem_r[pins.addr[3:0]];
  // a released bus shows the inverse of the last value
  assign dq_i = rd_on ? rd : ~last_r;
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      for (int i = 0; i < 16; i++) mem_r[i] <= 16'hFFFF;
      {wd_r, last_r, cnt_r, flt_r, tog_r, rd_d_r, wr_d_r, ers_r} <= '0;
    end
    else
    begin
      rd_d_r <= rd_on;
      wr_d_r <= !pins.ce_n && !pins.we_n;
      if (rd_on)
        last_r <= rd;
      if (rd_on && !rd_d_r && busy)
      begin
        tog_r <= !tog_r;
        cnt_r <= (cnt_r != 8'h00) ? cnt_r - 8'h01 : cnt_r;
      end
      if (wr_d_r && pins.we_n)
      begin
        // one reset word stands for both the plain and the abort reset
        if (pins.dq_o == RST_CMD)
          {flt_r, cnt_r, ers_r} <= '0;
        else if (!busy)
        begin
          wd_r <= pins.dq_o;
          cnt_r <= busy_len; // busy for busy_len status reads, then array data again unless a fault is held
          flt_r <= fault;
          ers_r <= (pins.dq_o == ERS_CMD);
          if (fault == 2'h0 && pins.dq_o == ERS_CMD)
            mem_r[pins.addr[3:0]] <= 16'hFFFF;
          else if (fault == 2'h0)
            mem_r[pins.addr[3:0]] <= mem_r[pins.addr[3:0]] & pins.dq_o;
        end
      end
    end
  end
endmodule // fws_flash_model

// file: sim/fws_host_tb.sv
/*
  fws_host_tb: drives fws_host over AXI4-Lite against the flash model.
  assumes: read results are queued by the driver and compared by a watcher.
*/
`timescale 1ns/100ps
module fws_host_tb;
  logic clk_sys, rst_b, s_axi_awvalid, s_axi_wvalid, s_axi_arvalid, ready_busy_n;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [7:0] s_axi_awaddr, s_axi_araddr, busy_len;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd_val;
  logic [1:0] s_axi_bresp, s_axi_rresp, fault;
  logic [15:0] dq_i, d, exp_w;
  logic [65:0] re;
  logic [65:0] rq[$];
  logic [1:0] bq[$];
  fws_pkg::fws_pins_t pins;
  int err_count, tests_run, seed, cyc;
  fws_host dut (.clk_sys, .rst_b, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb(4'hF), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready(1'h1), .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready(1'h1), .pins, .dq_i, .ready_busy_n);
  fws_flash_model u_flash (.clk_sys, .rst_b, .pins, .fault, .busy_len, .dq_i, .ready_busy_n);
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      err_count++;
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] v, input logic [1:0] r);
    bq.push_back(r);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    do
    begin
      @(posedge clk_sys);
      if (s_axi_awvalid && s_axi_awready)
        s_axi_awvalid <= 1'h0;
      if (s_axi_wvalid && s_axi_wready)
        s_axi_wvalid <= 1'h0;
    end
    while (s_axi_bvalid !== 1'h1);
  endtask
  task automatic axi_rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e,
    input logic [1:0] r);
    rq.push_back({r, m, e});
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    do @(posedge clk_sys); while (s_axi_arready !== 1'h1);
    s_axi_arvalid <= 1'h0;
    do @(posedge clk_sys); while (s_axi_rvalid !== 1'h1);
    rd_val = s_axi_rdata;
  endtask
  task automatic wait_idle();
    do axi_rd(fws_pkg::OFS_STATUS, '0, '0, fws_pkg::AXI_OKAY);
    while (rd_val[0] !== 1'h0);
  endtask
  task automatic run_op(input logic [31:0] ctrl, input logic [31:0] m, input logic [31:0] e);
    axi_wr(fws_pkg::OFS_CTRL, ctrl, fws_pkg::AXI_OKAY);
    wait_idle();
    axi_rd(fws_pkg::OFS_STATUS, m, e, fws_pkg::AXI_OKAY);
  endtask
  initial
  begin
    clk_sys = 1'h0;
    forever #50 clk_sys = !clk_sys;
  end
  always @(posedge clk_sys)
  begin
    if (s_axi_rvalid === 1'h1)
    begin
      re = rq.pop_front();
      if (re[63:32] != 32'h0000_0000)
        check("rdata", s_axi_rdata & re[63:32], re[31:0]);
      check("rresp", {30'h0, s_axi_rresp}, {30'h0, re[65:64]});
    end
    if (s_axi_bvalid === 1'h1)
      check("bresp", {30'h0, s_axi_bresp}, {30'h0, bq.pop_front()});
  end
  always @(posedge clk_sys)
  begin
    cyc++;
    if (cyc == 30000)
    begin
      err_count++;
      print_verdict();
    end
  end
  initial
  begin
    {rst_b, s_axi_awvalid, s_axi_wvalid, s_axi_arvalid, fault} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    busy_len = 8'h06;
    seed = 22320;
    repeat (10) @(posedge clk_sys);
    rst_b <= 1'h1;
    @(posedge clk_sys);
    axi_rd(fws_pkg::OFS_STATUS, '1, 32'h0000_0010, fws_pkg::AXI_OKAY);
    // every register but status resets to zero
    for (int i = 0; i < 6; i++)
      if (i != 3)
        axi_rd(8'(i * 4), '1, '0, fws_pkg::AXI_OKAY);
    axi_rd(8'h18, '1, '0, fws_pkg::AXI_SLVERR);
    axi_wr(8'h18, 32'h0000_0001, fws_pkg::AXI_SLVERR);
    axi_wr(fws_pkg::OFS_RSTW, 32'h0000_00F0, fws_pkg::AXI_OKAY);
    axi_rd(fws_pkg::OFS_RSTW, '1, 32'h0000_00F0, fws_pkg::AXI_OKAY);
    $display("test registers done");
    axi_wr(fws_pkg::OFS_ADDR, 32'h0000_0001, fws_pkg::AXI_OKAY);
    exp_w = 16'hFFFF;
    for (int i = 0; i < 3; i++)
    begin
      d = (16'($random(seed)) & 16'hFFDD) | 16'h0080;
      exp_w = exp_w & d;
      axi_wr(fws_pkg::OFS_WDATA, {16'h0000, d}, fws_pkg::AXI_OKAY);
      run_op(32'h0000_0009, '0, '0);
      run_op((i < 2) ? 32'h0000_000A : 32'h0000_000B, 32'h0000_000F, 32'h0000_0002);
      run_op(32'h0000_0008, '0, '0);
      axi_rd(fws_pkg::OFS_RDATA, 32'h0000_FFFF, {16'h0000, exp_w}, fws_pkg::AXI_OKAY);
    end
    $display("test program done");
    for (int k = 1; k < 3; k++)
    begin
      fault <= 2'(k);
      axi_wr(fws_pkg::OFS_ADDR, 32'(k + 2), fws_pkg::AXI_OKAY);
      axi_wr(fws_pkg::OFS_WDATA, 32'h0000_1230, fws_pkg::AXI_OKAY);
      run_op(32'h0000_0009, '0, '0);
      fault <= 2'h0;
      run_op(32'h0000_001A, 32'h0000_001F, (k == 1) ? 32'h0000_0014 : 32'h0000_0006);
      axi_wr(fws_pkg::OFS_WDATA, 32'h0000_00F0, fws_pkg::AXI_OKAY);
      run_op(32'h0000_0009, '0, '0);
      run_op(32'h0000_0008, '0, '0);
      axi_rd(fws_pkg::OFS_RDATA, 32'h0000_FFFF, 32'h0000_FFFF, fws_pkg::AXI_OKAY);
    end
    $display("test faults done");
    axi_wr(fws_pkg::OFS_ADDR, 32'h0000_0001, fws_pkg::AXI_OKAY);
    axi_wr(fws_pkg::OFS_WDATA, 32'h0000_0030, fws_pkg::AXI_OKAY);
    run_op(32'h0000_0009, '0, '0);
    run_op(32'h0000_0008, '0, '0);
    axi_rd(fws_pkg::OFS_RDATA, 32'h0000_00B8, 32'h0000_0008, fws_pkg::AXI_OKAY);
    run_op(32'h0000_000A, 32'h0000_000F, 32'h0000_0002);
    run_op(32'h0000_0008, '0, '0);
    axi_rd(fws_pkg::OFS_RDATA, 32'h0000_FFFF, 32'h0000_FFFF, fws_pkg::AXI_OKAY);
    $display("test erase done");
    busy_len <= 8'hFA;
    axi_wr(fws_pkg::OFS_ADDR, 32'h0000_0006, fws_pkg::AXI_OKAY);
    axi_wr(fws_pkg::OFS_WDATA, 32'h0000_1234, fws_pkg::AXI_OKAY);
    run_op(32'h0000_0009, '0, '0);
    axi_wr(fws_pkg::OFS_CTRL, 32'h0000_000A, fws_pkg::AXI_OKAY);
    run_op(32'h0000_0020, 32'h0000_001F, 32'h0000_0008);
    run_op(32'h0000_000A, 32'h0000_001F, 32'h0000_0012);
    $display("test stop done");
    print_verdict();
  end
endmodule // fws_host_tb
bind fws_host fws_host_monitor u_mon (.*);
